//--- core/sfcs_status.sv
`default_nettype none
module sfcs_status #(
  parameter int unsigned CNT_W = sfcs_pkg::CNT_W
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       sysResetEvent,
  input  wire logic       logicSelfTestRun,
  input  wire logic       wdCfgChange,
  input  wire logic       hostErrorMonitorConfig,
  input  wire logic       diagState,
  input  wire logic       cfgLock,
  input  wire logic       wdBadEvent,
  input  wire logic       hostErrorFail,
  input  wire logic [3:0] watchdogResetThreshold,
  input  wire logic [3:0] watchdogDriveOffThreshold,
  input  wire logic [3:0] hostErrorResetThreshold,
  input  wire logic [3:0] hostErrorDriveOffThreshold,
  input  wire logic       rdWdStatus,
  input  wire logic       rdHostStatus,
  input  wire logic       wrWdCounter,
  input  wire logic       wrHostCounter,
  input  wire logic [3:0] wrData,
  output logic [7:0]      wdStatus,
  output logic [7:0]      hostStatus
);

  if (CNT_W != sfcs_pkg::CNT_W) begin : g_cnt_w_check
    $error("counter width must be four");
  end

  typedef struct packed {
    logic       wdRst;
    logic       wdDrv;
    logic       wdFail;
    logic [3:0] wdCnt;
    logic       hRst;
    logic       hDrv;
    logic       hFail;
    logic [3:0] hCnt;
    logic       hCfgPrev;
    logic       hCfgValid;
  } sfcs_state_s;

  sfcs_state_s state_q;
  sfcs_state_s state_d;

  function automatic logic atLeast(input logic [3:0] cnt,
                                   input logic [3:0] th);
    atLeast = (cnt >= th);
  endfunction

  function automatic logic [3:0] incSat(input logic [3:0] cnt);
    incSat = (cnt == sfcs_pkg::CNT_MAX) ? cnt : cnt + 4'h1;
  endfunction

  logic wrAllowed;
  logic wdInit;
  logic hCfgChange;
  logic hInit;
  logic wdRstCond;
  logic wdDrvCond;
  logic hRstCond;
  logic hDrvCond;

  always_comb begin
    wrAllowed  = diagState && !cfgLock;
    wdInit     = sysResetEvent || logicSelfTestRun || wdCfgChange;
    hCfgChange = state_q.hCfgValid &&
                 (hostErrorMonitorConfig != state_q.hCfgPrev);
    hInit      = sysResetEvent || logicSelfTestRun || hCfgChange;
    // reset enable plays no part in this condition
    wdRstCond  = atLeast(state_q.wdCnt, watchdogResetThreshold);
    wdDrvCond  = atLeast(state_q.wdCnt, watchdogDriveOffThreshold);
    hRstCond   = atLeast(state_q.hCnt, hostErrorResetThreshold);
    hDrvCond   = atLeast(state_q.hCnt, hostErrorDriveOffThreshold);
  end

  always_comb begin
    state_d = state_q;
    state_d.hCfgPrev  = hostErrorMonitorConfig;
    state_d.hCfgValid = 1'b1;
    // latched flags; a read clears only an absent condition
    state_d.wdRst  = wdRstCond || (state_q.wdRst && !rdWdStatus);
    state_d.wdDrv  = wdDrvCond || (state_q.wdDrv && !rdWdStatus);
    state_d.wdFail = wdBadEvent || (state_q.wdFail && !rdWdStatus);
    state_d.hRst   = hRstCond || (state_q.hRst && !rdHostStatus);
    state_d.hDrv   = hDrvCond || (state_q.hDrv && !rdHostStatus);
    state_d.hFail  = hostErrorFail || (state_q.hFail && !rdHostStatus);
    if (wdBadEvent) begin
      state_d.wdCnt = incSat(state_q.wdCnt);
    end
    if (hostErrorFail) begin
      state_d.hCnt = incSat(state_q.hCnt);
    end
    if (wrWdCounter && wrAllowed) begin
      state_d.wdCnt = wrData;
    end
    if (wrHostCounter && wrAllowed) begin
      state_d.hCnt = wrData;
    end
    if (wdInit) begin
      state_d.wdDrv  = sfcs_pkg::WD_DRV_INIT;
      state_d.wdFail = sfcs_pkg::WATCHDOG_FAULT_FLAG_INIT;
      state_d.wdCnt  = watchdogDriveOffThreshold;
      if (logicSelfTestRun || wdCfgChange) begin
        state_d.wdRst = sfcs_pkg::WD_RST_INIT;
      end
    end
    if (hInit) begin
      state_d.hRst  = sfcs_pkg::H_RST_INIT;
      state_d.hDrv  = sfcs_pkg::H_DRV_INIT;
      state_d.hFail = sfcs_pkg::H_FAIL_INIT;
      state_d.hCnt  = sfcs_pkg::H_CNT_INIT;
    end
    if (reset) begin
      state_d.wdRst     = sfcs_pkg::WD_RST_INIT;
      state_d.wdDrv     = sfcs_pkg::WD_DRV_INIT;
      state_d.wdFail    = sfcs_pkg::WATCHDOG_FAULT_FLAG_INIT;
      state_d.wdCnt     = watchdogDriveOffThreshold;
      state_d.hRst      = sfcs_pkg::H_RST_INIT;
      state_d.hDrv      = sfcs_pkg::H_DRV_INIT;
      state_d.hFail     = sfcs_pkg::H_FAIL_INIT;
      state_d.hCnt      = sfcs_pkg::H_CNT_INIT;
      state_d.hCfgPrev  = 1'b0;
      state_d.hCfgValid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    state_q <= state_d;
  end

  // register images; top bit reads zero
  always_comb begin
    wdStatus = {1'b0, state_q.wdRst, state_q.wdDrv, state_q.wdFail,
                state_q.wdCnt};
    hostStatus = {1'b0, state_q.hRst, state_q.hDrv, state_q.hFail,
                  state_q.hCnt};
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_wd_quiet;
    !wdInit && !reset;
  endsequence

  property p_wd_rst_set;
    (wdRstCond and s_wd_quiet) |=> wdStatus[6];
  endproperty
  a_wd_rst_set: assert property (p_wd_rst_set)
    else $error("watchdog reset flag not set");

  property p_wd_rst_keep;
    (sysResetEvent && !logicSelfTestRun && !wdCfgChange && state_q.wdRst)
      |=> state_q.wdRst;
  endproperty
  a_wd_rst_keep: assert property (p_wd_rst_keep)
    else $error("watchdog reset flag lost on system reset");

  property p_wd_drv_init;
    wdInit |=> (state_q.wdDrv &&
                state_q.wdCnt == $past(watchdogDriveOffThreshold));
  endproperty
  a_wd_drv_init: assert property (p_wd_drv_init)
    else $error("watchdog init values wrong");

  property p_wd_event;
    (wdBadEvent && !wdInit && !(wrWdCounter && wrAllowed) &&
     state_q.wdCnt != sfcs_pkg::CNT_MAX)
      |=> (state_q.wdFail && state_q.wdCnt == $past(state_q.wdCnt) + 4'h1);
  endproperty
  a_wd_event: assert property (p_wd_event)
    else $error("watchdog event not counted");

  property p_wd_write_lock;
    (wrWdCounter && !wrAllowed && !wdBadEvent && !wdInit)
      |=> $stable(state_q.wdCnt);
  endproperty
  a_wd_write_lock: assert property (p_wd_write_lock)
    else $error("watchdog counter written while locked");

  property p_h_write;
    (wrHostCounter && wrAllowed && !hInit && !hostErrorFail &&
     !rdHostStatus)
      |=> (state_q.hCnt == $past(wrData) && $stable(state_q.hFail));
  endproperty
  a_h_write: assert property (p_h_write)
    else $error("host counter write wrong");

  property p_read_clear;
    (rdWdStatus && !wdBadEvent && !wdInit) |=> !state_q.wdFail;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("fail flag not cleared by read");

  property p_h_hold;
    (state_q.hFail && !rdHostStatus && !hInit) |=> state_q.hFail;
  endproperty
  a_h_hold: assert property (p_h_hold)
    else $error("host fail flag dropped without read");

  property p_h_init;
    hInit |=> (state_q.hCnt == sfcs_pkg::H_CNT_INIT && !state_q.hFail);
  endproperty
  a_h_init: assert property (p_h_init)
    else $error("host register not reinitialised");

  property p_h_drv;
    (hDrvCond && !hInit) |=> (state_q.hDrv && !hostStatus[7]);
  endproperty
  a_h_drv: assert property (p_h_drv)
    else $error("host drive-off flag not set");

endmodule
`default_nettype wire

//--- core/sfcs_pkg.sv
`default_nettype none
package sfcs_pkg;
  localparam int unsigned CNT_W        = 4;
  localparam int unsigned REG_W        = 8;
  // field positions inside both status registers
  localparam int unsigned RSV_BIT      = 7;
  localparam int unsigned RST_BIT      = 6;
  localparam int unsigned DRV_BIT      = 5;
  localparam int unsigned FAIL_BIT     = 4;
  localparam int unsigned CNT_LSB      = 0;
  // initial values and the counter maximum
  localparam logic        WD_RST_INIT  = 1'b0;
  localparam logic        WD_DRV_INIT  = 1'b1;
  localparam logic        WATCHDOG_FAULT_FLAG_INIT = 1'b0;
  localparam logic        H_RST_INIT   = 1'b0;
  localparam logic        H_DRV_INIT   = 1'b0;
  localparam logic        H_FAIL_INIT  = 1'b0;
  localparam logic [3:0]  H_CNT_INIT   = 4'h5;
  localparam logic [3:0]  CNT_MAX      = 4'hf;
endpackage
`default_nettype wire

//--- test/sfcs_host_model.sv
`default_nettype none
module sfcs_host_model (
  input  wire logic       ref_clk,
  input  wire logic       diagState,
  input  wire logic       cfgLock,
  output logic            rdWdStatus,
  output logic            rdHostStatus,
  output logic            wrWdCounter,
  output logic            wrHostCounter,
  output logic [3:0]      wrData
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {rdWdStatus, rdHostStatus, wrWdCounter, wrHostCounter} = 4'h0;
    wrData = 4'h0;
  end
  // one read a call; a repeat read confirms a flag cleared
  task automatic rd(input bit h);
    @(negedge ref_clk);
    if (h) rdHostStatus = 1'b1;
    else rdWdStatus = 1'b1;
    @(negedge ref_clk);
    {rdWdStatus, rdHostStatus} = 2'b00;
  endtask
  // writes only when unlocked in diagnostic state, unless told to misbehave
  task automatic wr(input bit h, input logic [3:0] v, input bit bad);
    @(negedge ref_clk);
    if (bad || (diagState && !cfgLock)) begin
      wrData = v;
      if (h) wrHostCounter = 1'b1;
      else wrWdCounter = 1'b1;
      @(negedge ref_clk);
      {wrWdCounter, wrHostCounter} = 2'b00;
      wrData = ~v;
    end
  endtask
endmodule
`default_nettype wire

//--- test/safety_fault_counter_status_tb.sv
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module safety_fault_counter_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk = 0, reset = 1, sysRst = 0, logic_self_test = 0, wdCfg = 0;
  logic       hCfg = 0, diag = 1, lock = 0, wdBad = 0, hFail = 0;
  logic       rdW, rdH, wrW, wrH;
  logic [3:0] wD, v, wdTh = 4'h6;
  logic [7:0] wdS, hS, expVal, q[$];
  int         fail_count = 0, n_checks = 0;
  initial forever #2 ref_clk = ~ref_clk;
  sfcs_host_model host (.ref_clk(ref_clk), .diagState(diag), .cfgLock(lock),
    .rdWdStatus(rdW), .rdHostStatus(rdH), .wrWdCounter(wrW),
    .wrHostCounter(wrH), .wrData(wD));
  sfcs_status dut (.ref_clk(ref_clk), .reset(reset), .sysResetEvent(sysRst),
    .logicSelfTestRun(logic_self_test), .wdCfgChange(wdCfg),
    .hostErrorMonitorConfig(hCfg), .diagState(diag), .cfgLock(lock),
    .wdBadEvent(wdBad), .hostErrorFail(hFail),
    .watchdogResetThreshold(4'h9), .watchdogDriveOffThreshold(wdTh),
    .hostErrorResetThreshold(4'h8), .hostErrorDriveOffThreshold(4'h7),
    .rdWdStatus(rdW), .rdHostStatus(rdH), .wrWdCounter(wrW),
    .wrHostCounter(wrH), .wrData(wD), .wdStatus(wdS), .hostStatus(hS));
  // read data is the status seen in the strobe's cycle
  always @(posedge ref_clk) if (rdW || rdH) begin
    expVal = q.pop_front();
    if (rdW) `CHK("wdStatus", expVal, wdS)
    else `CHK("hostStatus", expVal, hS)
  end
  task automatic ex(input bit h, input logic [7:0] e);
    q.push_back(e);
    host.rd(h);
  endtask
  task automatic pulse(ref logic s, input int n);
    repeat (n) begin
      @(negedge ref_clk);
      s = 1'b1;
      @(negedge ref_clk);
      s = 1'b0;
    end
  endtask
  function automatic logic [7:0] st(logic [3:0] c, logic [3:0] r,
                                    logic [3:0] d);
    return {1'b0, c >= r, c >= d, 1'b0, c};
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    v = 4'($urandom(32'h26e1));
    repeat (5) @(negedge ref_clk);
    reset = 1'b0;
    ex(0, 8'h26);
    ex(1, 8'h05);
    $display("test reset done");
    pulse(wdBad, 3);
    ex(0, 8'h79);
    ex(0, 8'h69);
    $display("test events done");
    v = 4'($urandom % 16);
    host.wr(0, v, 0);
    ex(0, 8'h60 | v);
    ex(0, st(v, 4'h9, 4'h6));
    lock = 1'b1;
    host.wr(0, ~v, 1);
    lock = 1'b0;
    diag = 1'b0;
    host.wr(0, ~v, 1);
    diag = 1'b1;
    ex(0, st(v, 4'h9, 4'h6));
    $display("test wd write done");
    host.wr(0, 4'hf, 0);
    pulse(wdBad, 1);
    ex(0, 8'h7f);
    pulse(sysRst, 1);
    ex(0, 8'h66);
    ex(0, 8'h26);
    $display("test sysreset done");
    pulse(hFail, 3);
    ex(1, 8'h78);
    ex(1, 8'h68);
    v = 4'($urandom % 16);
    host.wr(1, v, 0);
    ex(1, 8'h60 | v);
    ex(1, st(v, 4'h8, 4'h7));
    lock = 1'b1;
    host.wr(1, ~v, 1);
    lock = 1'b0;
    ex(1, st(v, 4'h8, 4'h7));
    $display("test host done");
    hCfg = 1'b1;
    ex(1, 8'h05);
    pulse(hFail, 1);
    pulse(logic_self_test, 1);
    ex(1, 8'h05);
    pulse(wdBad, 1);
    pulse(wdCfg, 1);
    ex(0, 8'h26);
    wdTh = 4'h3;
    pulse(wdCfg, 1);
    ex(0, 8'h23);
    $display("test init done");
    results();
  end
  initial begin
    #20000;
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
